/* sim/scf_dev_model.sv */
// behavioural device endpoint facing the host framer
`timescale 1ns/1ps
`default_nettype none
module scf_dev_model (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output var  logic       tx_ready_o,
  output var  logic [7:0] rx_data_o,
  output var  logic       rx_valid_o
);
  int         nak_n = 0, mute_n = 0, blocks = 0, bad = 0, slow = 0, want = 1;
  int         num[$], len[$];
  logic [7:0] endb[$], st = 8'h23, last = 8'h00;
  always @(posedge mclk_i) tx_ready_o <= !reset_i && (slow == 0 || !tx_ready_o);
  task automatic get(output logic [7:0] b);
    do @(posedge mclk_i); while (tx_valid_i !== 1'b1 || tx_ready_o !== 1'b1);
    b = tx_data_i;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge mclk_i);
    rx_data_o  <= b;
    rx_valid_o <= 1'b1;
    @(posedge mclk_i);
    rx_data_o  <= ~b;  // no stale byte left on the line
    rx_valid_o <= 1'b0;
  endtask
  // k spoils the checksum on purpose when nonzero
  task automatic frame(input logic [7:0] s, input logic [7:0] k);
    send(8'h02); send(8'h30); send(8'h30); send(8'h31); send(s); send(8'h03);
    send(8'hff ^ 8'h02 ^ 8'h30 ^ 8'h30 ^ 8'h31 ^ s ^ 8'h03 ^ k);
  endtask
  initial begin
    logic [7:0] b, e, x;
    int         n, d;
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    forever begin
      get(b);
      if (b != 8'h02) last = b;
      else begin
        x = 8'hfd;
        n = 0;
        d = 0;
        do begin
          get(b);
          if (b == 8'h02) begin
            x = 8'hff;
            n = -1;
            d = 0;
          end
          x ^= b;
          n++;
          if (n >= 1 && n <= 3) d = d * 10 + b - 8'h30;
        end while (b != 8'h03 && b != 8'h17);
        get(e);
        blocks++;
        num.push_back(d);
        len.push_back(n - 4);
        endb.push_back(b);
        if (e !== x) bad++;
        if (mute_n > 0) mute_n--;
        else if (e !== x || nak_n > 0 || d != want) begin
          if (nak_n > 0) nak_n--;
          send(8'h15);
        end else begin
          send(8'h06);
          want = (b == 8'h17) ? want + 1 : 1;
          if (b == 8'h03) frame(st, 8'h00);
        end
      end
    end
  end
endmodule  // scf_dev_model
`default_nettype wire

/* sim/scf_host_framer_sva.sv */
// assertion checker bound to the host framer
`timescale 1ns/1ps
`default_nettype none
module scf_chk (
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       msg_valid_i,
  input wire logic       msg_last_i,
  input wire logic       msg_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_ready_i,
  input wire logic [7:0] resp_data_o,
  input wire logic       resp_valid_o,
  input wire logic       resp_ok_o,
  input wire logic       resp_err_o,
  input wire logic       resp_frame_o,
  input wire logic       resp_block_ok_o,
  input wire logic       cmd_done_o,
  input wire logic       cmd_fail_o
);
  // ----
  // checksum of the block leaving on tx
  // ----
  logic       inb, ends;
  logic [7:0] acc;
  wire        tk = tx_valid_o && tx_ready_i;
  always @(posedge mclk_i) begin
    if (reset_i) begin
      inb  <= 1'b0;
      ends <= 1'b0;
      acc  <= 8'hff;
    end else if (tk && ends) begin
      inb  <= 1'b0;
      ends <= 1'b0;
    end else if (tk && (inb || tx_data_o == 8'h02)) begin
      inb  <= 1'b1;
      acc  <= (inb ? acc : 8'hff) ^ tx_data_o;
      ends <= inb && (tx_data_o == 8'h03 || tx_data_o == 8'h17);
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_last; msg_valid_i && msg_ready_o && msg_last_i; endsequence
  sequence s_stx; tx_valid_o && tx_data_o == 8'h02; endsequence
  chk_block_start: assert property (s_last |-> ##[2:6] s_stx)
    else $error("block did not open with start byte");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte changed before acceptance");
  chk_tx_gap: assert property (tk |=> !tx_valid_o)
    else $error("no idle cycle after tx byte");
  chk_lrc_value: assert property (tk && ends |-> tx_data_o == acc)
    else $error("wrong checksum byte");
  chk_ok_char: assert property (resp_ok_o |-> resp_valid_o && resp_data_o == 8'h23)
    else $error("ok status without its byte");
  chk_err_char: assert property (resp_err_o |-> resp_valid_o && resp_data_o == 8'h21)
    else $error("error status without its byte");
  chk_netid_skip: assert property (resp_valid_o |-> !(resp_data_o inside {8'h40, 8'h02, 8'h03}))
    else $error("control byte passed as content");
  chk_frame_good: assert property (resp_frame_o |-> resp_block_ok_o)
    else $error("frame end without good block");
  chk_done_fail: assert property (!(cmd_done_o && cmd_fail_o))
    else $error("done and fail together");
endmodule  // scf_chk
bind scf_host_framer scf_chk u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
  .msg_valid_i(msg_valid_i), .msg_last_i(msg_last_i), .msg_ready_o(msg_ready_o),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .resp_data_o(resp_data_o), .resp_valid_o(resp_valid_o), .resp_ok_o(resp_ok_o),
  .resp_err_o(resp_err_o), .resp_frame_o(resp_frame_o), .resp_block_ok_o(resp_block_ok_o),
  .cmd_done_o(cmd_done_o), .cmd_fail_o(cmd_fail_o));
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the host framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       mclk_i = 0, reset_i = 1, msg_valid_i = 0, msg_last_i = 0, tx_ready_i, rx_valid_i;
  logic [7:0] msg_data_i = 0, tx_data_o, rx_data_i, resp_data_o, r0;
  logic       msg_ready_o, tx_valid_o, resp_valid_o, ok, er, bok, bbad, frm, done, fail, busy_o;
  int         err_total = 0, tests_run = 0, cyc = 0, evt = 0, n_ok = 0, n_err = 0;
  int         n_bad = 0, n_done = 0, n_fail = 0, b0, n_frm = 0, n_byte = 0;
  always #10 mclk_i = ~mclk_i;
  scf_host_framer #(.TIMEOUT_CYC(27'd200)) DUT (.mclk_i(mclk_i), .reset_i(reset_i),
    .msg_data_i(msg_data_i), .msg_valid_i(msg_valid_i), .msg_last_i(msg_last_i),
    .msg_ready_o(msg_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .resp_data_o(resp_data_o), .resp_valid_o(resp_valid_o), .resp_ok_o(ok), .resp_err_o(er),
    .resp_block_ok_o(bok), .resp_block_bad_o(bbad), .resp_frame_o(frm), .cmd_done_o(done),
    .cmd_fail_o(fail), .busy_o(busy_o));
  scf_dev_model dev (.mclk_i(mclk_i), .reset_i(reset_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i),
    .rx_valid_o(rx_valid_i));
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (done === 1'b1 || fail === 1'b1 || bok === 1'b1 || bbad === 1'b1) evt <= evt + 1;
    if (ok === 1'b1) begin
      n_ok <= n_ok + 1;
      r0   <= resp_data_o;
    end
    if (er === 1'b1) n_err <= n_err + 1;
    if (bbad === 1'b1) n_bad <= n_bad + 1;
    if (done === 1'b1) n_done <= n_done + 1;
    if (fail === 1'b1) n_fail <= n_fail + 1;
    if (frm === 1'b1) n_frm <= n_frm + 1;
    if (resp_valid_o === 1'b1) n_byte <= n_byte + 1;
  end
  // whole run needs well under this many cycles
  always @(posedge mclk_i) if (cyc == 40000) begin
    err_total++;
    summarize();
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send_msg(input int n);
    for (int i = 0; i < n; i++) begin
      msg_data_i  <= (i == 0) ? 8'h20 : 8'h30 + 8'(i % 10);
      msg_last_i  <= (i == n - 1);
      msg_valid_i <= 1'b1;
      do @(posedge mclk_i); while (msg_ready_o !== 1'b1);
    end
    msg_valid_i <= 1'b0;
    msg_last_i  <= 1'b0;
  endtask
  // trailing wait covers the host ack that follows a checked block
  task automatic wait_evt(input int k);
    int t0  = evt;
    int lim = 0;
    while (evt < t0 + k && lim < 5000) begin
      @(posedge mclk_i);
      lim++;
    end
    chk(evt >= t0 + k, 1, "event count");
    repeat (8) @(posedge mclk_i);
  endtask
  task t_single;
    send_msg(3);
    wait_evt(2);
    chk(dev.num[$], 1, "block number");
    chk(dev.len[$], 3, "block length");
    chk(dev.endb[$], 8'h03, "end byte");
    chk(dev.bad, 0, "checksum faults");
    chk(r0, 8'h23, "status byte");
    chk(dev.last, 8'h06, "host ack");
    chk(n_frm, 1, "frame end");
    chk(n_byte, 1, "response bytes");
  endtask
  task t_multi;
    dev.slow = 1;
    send_msg(256);
    wait_evt(2);
    dev.slow = 0;
    chk(dev.num[$-1], 1, "first block number");
    chk(dev.len[$-1], 255, "first block length");
    chk(dev.endb[$-1], 8'h17, "first block end");
    chk(dev.num[$], 2, "final block number");
    chk(dev.len[$], 1, "final block length");
    chk(dev.endb[$], 8'h03, "final block end");
    chk(n_done, 2, "commands done");
  endtask
  task t_retry;
    b0 = dev.blocks;
    dev.nak_n = 2;
    send_msg(2);
    wait_evt(2);
    chk(dev.blocks - b0, 3, "resends");
    b0 = dev.blocks;
    dev.nak_n = 6;
    send_msg(2);
    wait_evt(1);
    chk(dev.blocks - b0, 6, "resend limit");
    chk(n_fail, 1, "command failed");
    b0 = dev.blocks;
    dev.mute_n = 1;
    send_msg(1);
    wait_evt(2);
    chk(dev.blocks - b0, 2, "timeout resend");
    chk(n_done, 4, "commands done");
  endtask
  task t_resp;
    dev.st = 8'h21;
    send_msg(1);
    wait_evt(2);
    dev.st = 8'h23;
    chk(n_err, 1, "error status");
    dev.frame(8'h23, 8'h01);
    repeat (8) @(posedge mclk_i);
    chk(n_bad, 1, "bad block");
    chk(dev.last, 8'h15, "host nak");
    dev.send(8'h02);
    dev.send(8'h30);
    dev.frame(8'h23, 8'h00);
    repeat (8) @(posedge mclk_i);
    chk(n_ok, 6, "restarted block");
    chk(dev.last, 8'h06, "ack after restart");
    chk(n_bad, 1, "no fault after restart");
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    chk({tx_valid_o, msg_ready_o, busy_o}, 3'h0, "reset outputs");
    @(posedge mclk_i);
    t_single();
    t_multi();
    t_retry();
    t_resp();
    summarize();
  end
endmodule  // testbench
`default_nettype wire

/* verilog/scf_consts.vh */
// constants for the host-side serial command framer
//
// What this block does
// - Host sends each command as one ASCII text message, control or query.
// - Every block starts with byte 02; receivers treat it as block start.
// - Last block of a frame ends with byte 03, completing the frame.
// - Non-final blocks end with byte 17.
// - Link positive acknowledge is byte 06, negative acknowledge is byte 15.
// - Byte 40 is the network frame identifier, never message content.
// - Block: start, three ASCII digit number, up to 255 chars, end, checksum.
// - Messages of 255 chars or fewer go as block 001 ending with 03.
// - Longer messages split into blocks from 001; non-final blocks hold 255 chars.
// - Final block carries the block count, remaining chars, and ends with 03.
// - Checksum starts at FF and XORs every block byte including start and end.
// - On negative acknowledge the sender retransmits, at most 5 times.
// - Host retransmits when no acknowledge arrives within 2 seconds.
`ifndef SCF_CONSTS_VH
`define SCF_CONSTS_VH

`define SCF_STX        8'h02
`define SCF_ETX        8'h03
`define SCF_ETB        8'h17
`define SCF_ACK        8'h06
`define SCF_NAK        8'h15
`define SCF_NETID      8'h40
`define SCF_APP_OK     8'h23
`define SCF_APP_ERR    8'h21
`define SCF_LRC_INIT   8'hff
`define SCF_ASCII_HI   4'h3
`define SCF_MAX_MSG    255
`define SCF_MAX_RETRY  5
`define SCF_TIMEOUT_MS 2000
`define SCF_CLK_KHZ    50000

`endif

/* verilog/scf_host_framer.v */
// host-side block framer, retry engine and response checker
`timescale 1ns/1ps
`default_nettype none
`include "scf_consts.vh"

module scf_host_framer #(
  parameter [26:0] TIMEOUT_CYC = `SCF_TIMEOUT_MS * `SCF_CLK_KHZ,
  parameter [7:0]  MAX_MSG     = `SCF_MAX_MSG,
  parameter [2:0]  MAX_RETRY   = `SCF_MAX_RETRY
) (
  input  wire       mclk_i,
  input  wire       reset_i,
  input  wire [7:0] msg_data_i,
  input  wire       msg_valid_i,
  input  wire       msg_last_i,
  output wire       msg_ready_o,
  output wire [7:0] tx_data_o,
  output wire       tx_valid_o,
  input  wire       tx_ready_i,
  input  wire [7:0] rx_data_i,
  input  wire       rx_valid_i,
  output wire [7:0] resp_data_o,
  output wire       resp_valid_o,
  output wire       resp_ok_o,
  output wire       resp_err_o,
  output wire       resp_block_ok_o,
  output wire       resp_block_bad_o,
  output wire       resp_frame_o,
  output wire       cmd_done_o,
  output wire       cmd_fail_o,
  output wire       busy_o
);

  // ----------------------------------------------------------------
  // transmit and receive states
  // ----------------------------------------------------------------
  localparam [2:0] T_IDLE = 3'd0;
  localparam [2:0] T_LOAD = 3'd1;
  localparam [2:0] T_STX  = 3'd2;
  localparam [2:0] T_NUM  = 3'd3;
  localparam [2:0] T_MSG  = 3'd4;
  localparam [2:0] T_END  = 3'd5;
  localparam [2:0] T_LRC  = 3'd6;
  localparam [2:0] T_WAIT = 3'd7;

  localparam [1:0] R_IDLE = 2'd0;
  localparam [1:0] R_NUM  = 2'd1;
  localparam [1:0] R_MSG  = 2'd2;
  localparam [1:0] R_LRC  = 2'd3;

  reg  [2:0]  tstate;
  reg  [7:0]  blk_buf [0:254];
  reg  [7:0]  wr_cnt;
  reg  [7:0]  rd_cnt;
  reg         final_blk;
  reg  [11:0] dig;
  reg  [1:0]  didx;
  reg  [7:0]  tx_lrc;
  reg  [2:0]  tries;
  reg  [26:0] tmr;
  reg  [7:0]  tx_data;
  reg         tx_valid;
  reg         cmd_done;
  reg         cmd_fail;

  reg  [1:0]  rstate;
  reg  [1:0]  rcnt;
  reg  [7:0]  rx_lrc;
  reg  [8:0]  rlen;
  reg         rfinal;
  reg         rframe_new;
  reg         blk_first;
  reg         ack_pend;
  reg  [7:0]  ack_byte;
  reg  [7:0]  resp_data;
  reg         resp_valid;
  reg         resp_ok;
  reg         resp_err;
  reg         blk_ok;
  reg         blk_bad;
  reg         frame_end;

  wire        ack_go;
  wire [7:0]  num_byte;
  wire        blk_good;

  // acks from the host only go out between blocks, never inside one
  assign ack_go = ack_pend && !tx_valid &&
                  (tstate == T_IDLE || tstate == T_LOAD || tstate == T_WAIT);
  assign num_byte = (didx == 2'd0) ? {`SCF_ASCII_HI, dig[11:8]} :
                    (didx == 2'd1) ? {`SCF_ASCII_HI, dig[7:4]} :
                                     {`SCF_ASCII_HI, dig[3:0]};
  assign blk_good = (rx_data_i == rx_lrc) && (rlen <= {1'b0, MAX_MSG});

  assign msg_ready_o      = (tstate == T_LOAD) && (wr_cnt < MAX_MSG);
  assign tx_data_o        = tx_data;
  assign tx_valid_o       = tx_valid;
  assign resp_data_o      = resp_data;
  assign resp_valid_o     = resp_valid;
  assign resp_ok_o        = resp_ok;
  assign resp_err_o       = resp_err;
  assign resp_block_ok_o  = blk_ok;
  assign resp_block_bad_o = blk_bad;
  assign resp_frame_o     = frame_end;
  assign cmd_done_o       = cmd_done;
  assign cmd_fail_o       = cmd_fail;
  assign busy_o           = (tstate != T_IDLE);

  function [11:0] bcd_inc;
    input [11:0] d;
    begin
      bcd_inc = d;
      if (d[3:0] != 4'd9) begin
        bcd_inc[3:0] = d[3:0] + 4'd1;
      end else begin
        bcd_inc[3:0] = 4'd0;
        if (d[7:4] != 4'd9) begin
          bcd_inc[7:4] = d[7:4] + 4'd1;
        end else begin
          bcd_inc[7:4]  = 4'd0;
          bcd_inc[11:8] = d[11:8] + 4'd1;
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // block builder and sender
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (reset_i) begin
      tstate    <= T_IDLE;
      wr_cnt    <= 8'h00;
      rd_cnt    <= 8'h00;
      final_blk <= 1'b0;
      dig       <= 12'h001;
      didx      <= 2'd0;
      tx_lrc    <= `SCF_LRC_INIT;
      tries     <= 3'd0;
      tmr       <= 27'h0000000;
      tx_data   <= 8'h00;
      tx_valid  <= 1'b0;
      cmd_done  <= 1'b0;
      cmd_fail  <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      cmd_fail <= 1'b0;
      if (tx_valid && tx_ready_i) begin
        tx_valid <= 1'b0;
      end
      if (ack_go) begin
        tx_data  <= ack_byte;
        tx_valid <= 1'b1;
      end
      case (tstate)
        T_IDLE: begin
          if (msg_valid_i) begin
            tstate <= T_LOAD;
            dig    <= 12'h001;
            tries  <= 3'd0;
            wr_cnt <= 8'h00;
          end
        end
        T_LOAD: begin
          if (msg_valid_i && msg_ready_o) begin
            blk_buf[wr_cnt] <= msg_data_i;
            wr_cnt          <= wr_cnt + 8'd1;
            if (msg_last_i || wr_cnt == MAX_MSG - 8'd1) begin
              final_blk <= msg_last_i;
              tstate    <= T_STX;
            end
          end
        end
        T_STX: begin
          if (!tx_valid) begin
            tx_data  <= `SCF_STX;
            tx_valid <= 1'b1;
            tx_lrc   <= `SCF_LRC_INIT ^ `SCF_STX;
            rd_cnt   <= 8'h00;
            didx     <= 2'd0;
            tstate   <= T_NUM;
          end
        end
        T_NUM: begin
          if (!tx_valid) begin
            tx_data  <= num_byte;
            tx_valid <= 1'b1;
            tx_lrc   <= tx_lrc ^ num_byte;
            didx     <= didx + 2'd1;
            if (didx == 2'd2) begin
              tstate <= (wr_cnt == 8'h00) ? T_END : T_MSG;
            end
          end
        end
        T_MSG: begin
          if (!tx_valid) begin
            tx_data  <= blk_buf[rd_cnt];
            tx_valid <= 1'b1;
            tx_lrc   <= tx_lrc ^ blk_buf[rd_cnt];
            rd_cnt   <= rd_cnt + 8'd1;
            if (rd_cnt == wr_cnt - 8'd1) begin
              tstate <= T_END;
            end
          end
        end
        T_END: begin
          if (!tx_valid) begin
            tx_data  <= final_blk ? `SCF_ETX : `SCF_ETB;
            tx_valid <= 1'b1;
            tx_lrc   <= tx_lrc ^ (final_blk ? `SCF_ETX : `SCF_ETB);
            tstate   <= T_LRC;
          end
        end
        T_LRC: begin
          if (!tx_valid) begin
            tx_data  <= tx_lrc;
            tx_valid <= 1'b1;
            tmr      <= 27'h0000000;
            tstate   <= T_WAIT;
          end
        end
        T_WAIT: begin
          tmr <= tmr + 27'd1;
          if (rx_valid_i && rx_data_i == `SCF_ACK) begin
            if (final_blk) begin
              cmd_done <= 1'b1;
              tstate   <= T_IDLE;
            end else begin
              dig    <= bcd_inc(dig);
              wr_cnt <= 8'h00;
              tries  <= 3'd0;
              tstate <= T_LOAD;
            end
          end else if ((rx_valid_i && rx_data_i == `SCF_NAK) ||
                       tmr == TIMEOUT_CYC - 27'd1) begin
            if (tries == MAX_RETRY) begin
              cmd_fail <= 1'b1;
              tstate   <= T_IDLE;
            end else begin
              tries  <= tries + 3'd1;
              tstate <= T_STX;
            end
          end
        end
        default: tstate <= T_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // response block checker
  // ----------------------------------------------------------------
  // message bytes are passed on as they arrive; a bad checksum is only
  // known at block end, so the user must drop a block flagged bad
  always @(posedge mclk_i) begin
    if (reset_i) begin
      rstate     <= R_IDLE;
      rcnt       <= 2'd0;
      rx_lrc     <= `SCF_LRC_INIT;
      rlen       <= 9'h000;
      rfinal     <= 1'b0;
      rframe_new <= 1'b1;
      blk_first  <= 1'b1;
      ack_pend   <= 1'b0;
      ack_byte   <= `SCF_ACK;
      resp_data  <= 8'h00;
      resp_valid <= 1'b0;
      resp_ok    <= 1'b0;
      resp_err   <= 1'b0;
      blk_ok     <= 1'b0;
      blk_bad    <= 1'b0;
      frame_end  <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      resp_ok    <= 1'b0;
      resp_err   <= 1'b0;
      blk_ok     <= 1'b0;
      blk_bad    <= 1'b0;
      frame_end  <= 1'b0;
      if (ack_go) begin
        ack_pend <= 1'b0;
      end
      if (rx_valid_i) begin
        if (rx_data_i == `SCF_STX) begin
          rstate <= R_NUM;
          rcnt   <= 2'd0;
          rx_lrc <= `SCF_LRC_INIT ^ `SCF_STX;
          rlen   <= 9'h000;
          blk_first <= rframe_new;
        end else begin
          case (rstate)
            R_IDLE: rstate <= R_IDLE;
            R_NUM: begin
              rx_lrc <= rx_lrc ^ rx_data_i;
              rcnt   <= rcnt + 2'd1;
              if (rcnt == 2'd2) begin
                rstate <= R_MSG;
              end
            end
            R_MSG: begin
              rx_lrc <= rx_lrc ^ rx_data_i;
              if (rx_data_i == `SCF_ETX || rx_data_i == `SCF_ETB) begin
                rfinal <= (rx_data_i == `SCF_ETX);
                rstate <= R_LRC;
              end else if (rx_data_i != `SCF_NETID) begin
                rlen       <= rlen + 9'd1;
                resp_data  <= rx_data_i;
                resp_valid <= 1'b1;
                resp_ok    <= blk_first && (rlen == 9'h000) && (rx_data_i == `SCF_APP_OK);
                resp_err   <= blk_first && (rlen == 9'h000) && (rx_data_i == `SCF_APP_ERR);
              end
            end
            R_LRC: begin
              ack_pend  <= 1'b1;
              ack_byte  <= blk_good ? `SCF_ACK : `SCF_NAK;
              blk_ok    <= blk_good;
              blk_bad   <= !blk_good;
              frame_end <= blk_good && rfinal;
              // a block flagged bad keeps its frame position for the resend
              if (blk_good) begin
                rframe_new <= rfinal;
              end
              rstate <= R_IDLE;
            end
            default: rstate <= R_IDLE;
          endcase
        end
      end
    end
  end

endmodule // scf_host_framer

`default_nettype wire
